//--- rtl/cqc_txq_ctrl.sv
// Operation
// - Writing one to reset request resets the queue; hardware clears it when done.
// - Reset request held set in configuration mode, cleared in normal mode.
// - Send request starts transmission; clears itself once every queued message is sent.
// - Writing zero to a set send request asks to abort the pending message.
// - Send request refreshed on message completion, abort and queue reset.
// - Head increment advances the head by exactly one slot and self-clears.
// - Transmit enable bit always reads one.
// - Three enables gate attempts-exhausted, empty and not-full interrupts.
// - Current index reads the slot to be transmitted next.
// - Current index is zero-based, from zero to depth minus one.
// - Aborted flag is one after abort, zero after successful completion.
// - Lost-arbitration flag set when the message loses arbitration.
// - Transmit error flag set when a bus error occurs during sending.
// - Outcome flags clear on send request set or on SPI write of zero.
// - Aborted flag updated on completion and abort; all outcome flags cleared on queue reset.
// - Attempts-exhausted flag set by hardware, held until software clears it.
// - Empty flag read-only, one when nothing queued, one after reset.
// - Unimplemented bits ignore writes and read zero.
// - Depth field value plus one gives the queue depth, one to thirty-two.
`timescale 1ns/1ps
`default_nettype none
module cqc_txq_ctrl (
    input wire logic mclk,
    input wire logic rst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    input wire logic config_mode,
    input wire logic [4:0] queue_depth,
    input wire cqc_pkg::cqc_event_t evt,
    output logic send_request,
    output logic abort_pulse,
    output logic queue_reset_request,
    output cqc_pkg::cqc_queue_t queue,
    output cqc_pkg::cqc_irq_t irq
);
    import cqc_pkg::*;

    logic [2:0] pins_s;
    logic [11:0] addr;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] ctrl_rd;
    logic [31:0] stat_rd;
    logic wr_ctrl;
    logic wr_stat;
    logic att_ie;
    logic empty_ie;
    logic nfull_ie;
    logic aborted_flag;
    logic lost_arbitration_flag;
    logic transmit_error_flag;
    logic attempts_exhausted_flag;
    logic queue_empty_flag;
    logic queue_not_full_flag;
    logic [5:0] depth;
    logic inc;
    logic done;
    logic set_req;
    logic [5:0] next_count;

    // Pins from the host are asynchronous to mclk
    cqc_sync #(.W(3)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .d({spi_sck, spi_cs_n, spi_sdi}),
        .q(pins_s)
    );

    cqc_spi_slave u_spi (
        .mclk(mclk),
        .rst(rst),
        .sck(pins_s[2]),
        .cs_n(pins_s[1]),
        .sdi(pins_s[0]),
        .rdata(rdata),
        .addr(addr),
        .wr(wr),
        .wdata(wdata),
        .sdo(spi_sdo)
    );

    // Decode and queue arithmetic
    assign wr_ctrl = wr && addr == CQC_CTRL_ADDR;
    assign wr_stat = wr && addr == CQC_STAT_ADDR;
    assign depth = {1'b0, queue_depth} + 6'h01;
    assign queue_empty_flag = queue.count == 6'h00;
    assign queue_not_full_flag = queue.count != depth;
    // A full queue or a pending reset swallows the increment
    assign inc = wr_ctrl && wdata[CQC_HEAD_INC_BIT] && !queue_reset_request
        && queue_not_full_flag;
    assign done = evt.done && send_request && !queue_empty_flag && !queue_reset_request;
    assign set_req = wr_ctrl && wdata[CQC_SEND_REQ_BIT] && !queue_reset_request;
    assign next_count = queue.count + {5'h00, inc} - {5'h00, done};

    // Read views; unlisted bits stay zero
    always_comb begin
        ctrl_rd = CQC_ZERO_WORD;
        ctrl_rd[CQC_RST_REQ_BIT] = queue_reset_request;
        ctrl_rd[CQC_SEND_REQ_BIT] = send_request;
        ctrl_rd[CQC_TX_EN_BIT] = CQC_TX_EN_VAL;
        ctrl_rd[CQC_ATT_IE_BIT] = att_ie;
        ctrl_rd[CQC_EMPTY_IE_BIT] = empty_ie;
        ctrl_rd[CQC_NFULL_IE_BIT] = nfull_ie;
        stat_rd = CQC_ZERO_WORD;
        stat_rd[CQC_CI_MSB:CQC_CI_LSB] = queue.current_index;
        stat_rd[CQC_ABT_BIT] = aborted_flag;
        stat_rd[CQC_LARB_BIT] = lost_arbitration_flag;
        stat_rd[CQC_ERR_BIT] = transmit_error_flag;
        stat_rd[CQC_ATT_IF_BIT] = attempts_exhausted_flag;
        stat_rd[CQC_EMPTY_IF_BIT] = queue_empty_flag;
        stat_rd[CQC_NFULL_IF_BIT] = queue_not_full_flag;
        if (addr == CQC_CTRL_ADDR) begin
            rdata = ctrl_rd;
        end else if (addr == CQC_STAT_ADDR) begin
            rdata = stat_rd;
        end else begin
            rdata = CQC_ZERO_WORD;
        end
    end

    // Reset request: held in configuration mode, one cycle otherwise
    always_ff @(posedge mclk) begin
        if (rst) begin
            queue_reset_request <= CQC_RST_REQ_RST;
        end else if (config_mode) begin
            queue_reset_request <= 1'b1;
        end else if (wr_ctrl && wdata[CQC_RST_REQ_BIT]) begin
            queue_reset_request <= 1'b1;
        end else begin
            queue_reset_request <= 1'b0;
        end
    end

    // Queue pointers, cleared while the reset request stands
    always_ff @(posedge mclk) begin
        if (rst || queue_reset_request) begin
            queue <= '0;
        end else begin
            queue.count <= next_count;
            if (inc) begin
                queue.head <= (queue.head == queue_depth) ? 5'h00 : queue.head + 5'h01;
            end
            if (done) begin
                // Wraps at the configured depth so the index stays in range
                queue.current_index <= (queue.current_index == queue_depth) ? 5'h00
                    : queue.current_index + 5'h01;
            end
        end
    end

    // Send request and abort strobe
    // A queue reset outranks a same-cycle set, abort or completion
    always_ff @(posedge mclk) begin
        if (rst) begin
            send_request <= 1'b0;
            abort_pulse <= 1'b0;
        end else begin
            abort_pulse <= wr_ctrl && !wdata[CQC_SEND_REQ_BIT] && send_request
                && !queue_reset_request;
            if (queue_reset_request) begin
                send_request <= 1'b0;
            end else if (set_req) begin
                send_request <= 1'b1;
            end else if (wr_ctrl && send_request) begin
                send_request <= 1'b0;
            end else if (evt.aborted) begin
                send_request <= 1'b0;
            end else if (next_count == 6'h00) begin
                send_request <= 1'b0;
            end
        end
    end

    // Interrupt enables
    always_ff @(posedge mclk) begin
        if (rst) begin
            att_ie <= 1'b0;
            empty_ie <= 1'b0;
            nfull_ie <= 1'b0;
        end else if (wr_ctrl) begin
            att_ie <= wdata[CQC_ATT_IE_BIT];
            empty_ie <= wdata[CQC_EMPTY_IE_BIT];
            nfull_ie <= wdata[CQC_NFULL_IE_BIT];
        end
    end

    // Outcome flags; a hardware set beats a same-cycle clear
    // Queue reset outranks events, since the message they describe is gone
    always_ff @(posedge mclk) begin
        if (rst || queue_reset_request) begin
            aborted_flag <= 1'b0;
            lost_arbitration_flag <= 1'b0;
            transmit_error_flag <= 1'b0;
        end else begin
            if (evt.aborted) begin
                aborted_flag <= 1'b1;
            end else if (done || set_req || (wr_stat && !wdata[CQC_ABT_BIT])) begin
                aborted_flag <= 1'b0;
            end
            if (evt.lost_arb) begin
                lost_arbitration_flag <= 1'b1;
            end else if (set_req || (wr_stat && !wdata[CQC_LARB_BIT])) begin
                lost_arbitration_flag <= 1'b0;
            end
            if (evt.bus_err) begin
                transmit_error_flag <= 1'b1;
            end else if (set_req || (wr_stat && !wdata[CQC_ERR_BIT])) begin
                transmit_error_flag <= 1'b0;
            end
        end
    end

    // Sticky attempts-exhausted flag, cleared only by software
    always_ff @(posedge mclk) begin
        if (rst) begin
            attempts_exhausted_flag <= 1'b0;
        end else if (evt.exhausted) begin
            attempts_exhausted_flag <= 1'b1;
        end else if (wr_stat && !wdata[CQC_ATT_IF_BIT]) begin
            attempts_exhausted_flag <= 1'b0;
        end
    end

    // Registered interrupt sources toward the interrupt logic
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq <= '0;
        end else begin
            irq.att <= attempts_exhausted_flag && att_ie;
            irq.empty <= queue_empty_flag && empty_ie;
            irq.nfull <= queue_not_full_flag && nfull_ie;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_abort_write;
        wr_ctrl && !wdata[CQC_SEND_REQ_BIT] && send_request && !queue_reset_request;
    endsequence

    sequence s_send_write;
        set_req && !evt.aborted && !evt.lost_arb && !evt.bus_err;
    endsequence

    sequence s_head_step;
        inc && !config_mode;
    endsequence

    rst_done_a: assert property (queue_reset_request && !config_mode
        && !(wr_ctrl && wdata[CQC_RST_REQ_BIT]) |=> !queue_reset_request)
        else $error("reset request did not clear");

    cfg_hold_a: assert property (config_mode |=> queue_reset_request ##1
        queue.count == 6'h00)
        else $error("reset request not held in configuration mode");

    abort_req_a: assert property (s_abort_write |=> abort_pulse && !send_request)
        else $error("abort write not honoured");

    reset_refresh_a: assert property (queue_reset_request |=> !send_request
        && !aborted_flag && !lost_arbitration_flag && !transmit_error_flag
        && queue.count == 6'h00)
        else $error("queue reset left state behind");

    head_step_a: assert property (s_head_step |=> queue.count == $past(queue.count)
        + 6'h01 - {5'h00, $past(done)})
        else $error("head increment not by one");

    ci_range_a: assert property ($stable(queue_depth) && queue.current_index <= queue_depth
        |=> queue.current_index <= queue_depth)
        else $error("current index out of range");

    abort_flag_a: assert property (evt.aborted && !queue_reset_request
        |=> aborted_flag ##1 (aborted_flag || $past(wr_stat || set_req || done)
        || $past(queue_reset_request)))
        else $error("aborted flag lost");

    outcome_clr_a: assert property (s_send_write |=> !aborted_flag
        && !lost_arbitration_flag && !transmit_error_flag)
        else $error("outcome flags not cleared by send request");

    att_sticky_a: assert property (attempts_exhausted_flag
        && !(wr_stat && !wdata[CQC_ATT_IF_BIT]) |=> attempts_exhausted_flag)
        else $error("attempts flag dropped");

    irq_gate_a: assert property (irq.empty == $past(queue_empty_flag && empty_ie)
        && irq.nfull == $past(queue_not_full_flag && nfull_ie))
        else $error("interrupt source not gated by enable");

    send_clear_a: assert property (send_request && queue.count == 6'h01 && done
        && !inc && !wr_ctrl |=> !send_request)
        else $error("send request not cleared after last message");

    // Field-level checks, one register rule each

    reset_write_a: assert property (wr_ctrl && wdata[CQC_RST_REQ_BIT]
        |=> queue_reset_request)
        else $error("reset request write not taken");

    send_start_a: assert property (set_req |=> send_request)
        else $error("send request write not taken");

    abort_refresh_a: assert property (evt.aborted && !set_req
        |=> !send_request)
        else $error("send request kept after abort event");

    // Full queue must refuse the increment, otherwise count overruns depth
    head_full_a: assert property (!queue_not_full_flag && !done && !queue_reset_request
        |=> queue.count == $past(queue.count))
        else $error("increment accepted on full queue");

    ci_step_a: assert property (done && queue.current_index != queue_depth
        |=> queue.current_index == $past(queue.current_index) + 5'h01)
        else $error("current index did not advance");

    larb_set_a: assert property (evt.lost_arb && !queue_reset_request
        |=> lost_arbitration_flag)
        else $error("lost arbitration flag not set");

    err_set_a: assert property (evt.bus_err && !queue_reset_request
        |=> transmit_error_flag)
        else $error("transmit error flag not set");

    // Enables follow every control write, all three at once
    ie_write_a: assert property (wr_ctrl |=> att_ie == $past(wdata[CQC_ATT_IE_BIT])
        && empty_ie == $past(wdata[CQC_EMPTY_IE_BIT])
        && nfull_ie == $past(wdata[CQC_NFULL_IE_BIT]))
        else $error("interrupt enable not written");

    att_gate_a: assert property (irq.att == $past(attempts_exhausted_flag && att_ie))
        else $error("attempts source not gated by enable");

    att_clear_a: assert property (wr_stat && !wdata[CQC_ATT_IF_BIT]
        && !evt.exhausted |=> !attempts_exhausted_flag)
        else $error("attempts flag not cleared by software");
endmodule
`default_nettype wire

//--- rtl/cqc_pkg.sv
package cqc_pkg;

    // Register word addresses inside the SPI space
    localparam logic [11:0] CQC_CTRL_ADDR = 12'h050;
    localparam logic [11:0] CQC_STAT_ADDR = 12'h054;

    // SPI command nibbles
    localparam logic [3:0] CQC_CMD_WRITE = 4'h2;
    localparam logic [3:0] CQC_CMD_READ = 4'h3;
    localparam int CQC_SPI_HDR_BITS = 16;
    localparam int CQC_SPI_FRAME_BITS = 48;

    // Control register fields
    localparam int CQC_RST_REQ_BIT = 10;
    localparam int CQC_SEND_REQ_BIT = 9;
    localparam int CQC_HEAD_INC_BIT = 8;
    localparam int CQC_TX_EN_BIT = 7;
    localparam int CQC_ATT_IE_BIT = 4;
    localparam int CQC_EMPTY_IE_BIT = 2;
    localparam int CQC_NFULL_IE_BIT = 0;

    // Status register fields
    localparam int CQC_CI_LSB = 8;
    localparam int CQC_CI_MSB = 12;
    localparam int CQC_ABT_BIT = 7;
    localparam int CQC_LARB_BIT = 6;
    localparam int CQC_ERR_BIT = 5;
    localparam int CQC_ATT_IF_BIT = 4;
    localparam int CQC_EMPTY_IF_BIT = 2;
    localparam int CQC_NFULL_IF_BIT = 0;

    // Reset values
    localparam logic CQC_RST_REQ_RST = 1'b1;
    localparam logic CQC_TX_EN_VAL = 1'b1;
    localparam logic [31:0] CQC_ZERO_WORD = 32'h0000_0000;

    // Pulses from the bus engine, one cycle each
    typedef struct packed {
        logic done;
        logic aborted;
        logic lost_arb;
        logic bus_err;
        logic exhausted;
    } cqc_event_t;

    // Queue pointers as seen by the message RAM side
    typedef struct packed {
        logic [4:0] current_index;
        logic [4:0] head;
        logic [5:0] count;
    } cqc_queue_t;

    // Gated interrupt sources
    typedef struct packed {
        logic att;
        logic empty;
        logic nfull;
    } cqc_irq_t;

endpackage

//--- rtl/cqc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cqc_sync #(
    parameter int W = 3
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // Two flops per bit; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta;
            always_ff @(posedge mclk) begin
                if (rst) begin
                    meta <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta <= d[i];
                    q[i] <= meta;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- rtl/cqc_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
module cqc_spi_slave (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic [31:0] rdata,
    output logic [11:0] addr,
    output logic wr,
    output logic [31:0] wdata,
    output logic sdo
);
    import cqc_pkg::*;

    logic sck_q;
    logic [5:0] bitcnt;
    logic [15:0] hdr;
    logic [31:0] dsh;
    logic [31:0] osh;
    logic [3:0] cmd;
    logic load;
    logic rise;
    logic fall;

    // Edges of the already synchronised serial clock (mode 0,0)
    assign rise = sck & ~sck_q & ~cs_n;
    assign fall = ~sck & sck_q & ~cs_n;

    // Header and data shift; write issued on last data bit
    always_ff @(posedge mclk) begin
        if (rst) begin
            sck_q <= 1'b0;
            bitcnt <= 6'h00;
            hdr <= 16'h0000;
            dsh <= CQC_ZERO_WORD;
            cmd <= 4'h0;
            addr <= 12'h000;
            wr <= 1'b0;
            wdata <= CQC_ZERO_WORD;
            load <= 1'b0;
        end else begin
            sck_q <= sck;
            wr <= 1'b0;
            load <= 1'b0;
            if (cs_n) begin
                bitcnt <= 6'h00;
            end else if (rise) begin
                bitcnt <= bitcnt + 6'h01;
                if (bitcnt < 6'(CQC_SPI_HDR_BITS)) begin
                    hdr <= {hdr[14:0], sdi};
                end else begin
                    dsh <= {dsh[30:0], sdi};
                end
                if (bitcnt == 6'(CQC_SPI_HDR_BITS - 1)) begin
                    cmd <= hdr[14:11];
                    addr <= {hdr[10:0], sdi};
                    load <= 1'b1;
                end
                if (bitcnt == 6'(CQC_SPI_FRAME_BITS - 1) && cmd == CQC_CMD_WRITE) begin
                    wr <= 1'b1;
                    wdata <= {dsh[30:0], sdi};
                end
            end
        end
    end

    // Read word captured once the address is known, shifted out MSB first
    always_ff @(posedge mclk) begin
        if (rst) begin
            osh <= CQC_ZERO_WORD;
            sdo <= 1'b0;
        end else if (load) begin
            osh <= (cmd == CQC_CMD_READ) ? rdata : CQC_ZERO_WORD;
        end else if (fall && bitcnt >= 6'(CQC_SPI_HDR_BITS)) begin
            sdo <= osh[31];
            osh <= {osh[30:0], 1'b0};
        end
    end
endmodule
`default_nettype wire

//--- test/cqc_host.sv
`timescale 1ns/1ps
`default_nettype none
module cqc_host (
    input wire logic mclk,
    input wire logic sdo,
    output logic sck,
    output logic cs_n,
    output logic sdi
);
    import cqc_pkg::*;

    // Idle bus: clock parked low, chip deselected
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // One 48-bit frame, sck at mclk/8, bits set while sck is low
    task automatic xfer(input logic [3:0] cmd, input logic [11:0] adr,
                        input logic [31:0] wd, output logic [31:0] rd);
        logic [47:0] frame;
        frame = {cmd, adr, wd};
        rd = CQC_ZERO_WORD;
        @(negedge mclk);
        cs_n = 1'b0;
        for (int i = 47; i >= 0; i--) begin
            sdi = frame[i];
            repeat (4) @(negedge mclk);
            sck = 1'b1;
            if (i < 32) rd = {rd[30:0], sdo};
            repeat (4) @(negedge mclk);
            sck = 1'b0;
        end
        // Released data line must not look like the last bit
        sdi = ~frame[0];
        repeat (2) @(negedge mclk);
        cs_n = 1'b1;
        // Gap covers the write latency and the deselect time
        repeat (6) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

//--- test/cqc_txq_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module cqc_txq_ctrl_tb;
    import cqc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic config_mode = 1'b1;
    logic [4:0] queue_depth = 5'h03;
    cqc_event_t evt = '0;
    logic sck, cs_n, sdi, sdo, send_request, abort_pulse, queue_reset_request;
    cqc_queue_t queue;
    cqc_irq_t irq;
    int bad_count = 0;
    int num_checks = 0;
    int abort_seen = 0;
    logic [31:0] r;

    always #20 mclk = ~mclk;

    cqc_txq_ctrl u_dut (.mclk(mclk), .rst(rst), .spi_sck(sck), .spi_cs_n(cs_n),
        .spi_sdi(sdi), .spi_sdo(sdo), .config_mode(config_mode),
        .queue_depth(queue_depth), .evt(evt), .send_request(send_request),
        .abort_pulse(abort_pulse), .queue_reset_request(queue_reset_request),
        .queue(queue), .irq(irq));
    cqc_host u_host (.mclk(mclk), .sdo(sdo), .sck(sck), .cs_n(cs_n), .sdi(sdi));

    // Abort is a one-cycle pulse, so count it as it passes
    always @(posedge mclk) begin
        if (abort_pulse === 1'b1) abort_seen++;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        u_host.xfer(CQC_CMD_WRITE, a, d, x);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        u_host.xfer(CQC_CMD_READ, a, CQC_ZERO_WORD, d);
    endtask
    // Event order: done, aborted, lost_arb, bus_err, exhausted
    task automatic ev(input logic [4:0] e);
        @(negedge mclk);
        evt = cqc_event_t'(e);
        @(negedge mclk);
        evt = '0;
        repeat (2) @(negedge mclk);
    endtask

    task automatic wrap_up;
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Reset request follows the mode, fixed enable and flags at reset
    task automatic s_reset;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        `CHK("rst_req_cfg", 1'b1, queue_reset_request)
        config_mode = 1'b0;
        repeat (3) @(negedge mclk);
        `CHK("rst_req_norm", 1'b0, queue_reset_request)
        rd(CQC_CTRL_ADDR, r);
        `CHK("ctrl_rst", 32'h0000_0080, r)
        rd(CQC_STAT_ADDR, r);
        `CHK("stat_rst", 32'h0000_0005, r)
    endtask

    // Four-deep queue filled past full
    task automatic s_fill;
        for (int i = 1; i <= 5; i++) begin
            wr(CQC_CTRL_ADDR, 32'h0000_0100);
            `CHK("count", 6'((i > 4) ? 4 : i), queue.count)
            `CHK("head", 5'((i > 3) ? 0 : i), queue.head)
        end
        rd(CQC_CTRL_ADDR, r);
        `CHK("inc_clear", 1'b0, r[CQC_HEAD_INC_BIT])
        rd(CQC_STAT_ADDR, r);
        `CHK("full", 2'b00, {r[CQC_NFULL_IF_BIT], r[CQC_EMPTY_IF_BIT]})
    endtask

    // Send all four with arbitration loss and bus error on the way
    task automatic s_send;
        wr(CQC_CTRL_ADDR, 32'h0000_0200);
        `CHK("send_set", 1'b1, send_request)
        ev(5'b00100);
        ev(5'b00010);
        rd(CQC_STAT_ADDR, r);
        `CHK("larb", 1'b1, r[CQC_LARB_BIT])
        `CHK("berr", 1'b1, r[CQC_ERR_BIT])
        wr(CQC_STAT_ADDR, CQC_ZERO_WORD);
        rd(CQC_STAT_ADDR, r);
        `CHK("flags_clr", 4'h0, r[7:4])
        for (int i = 1; i <= 4; i++) begin
            ev(5'b10000);
            `CHK("cur_idx", 5'(i % 4), queue.current_index)
            `CHK("left", 6'(4 - i), queue.count)
        end
        `CHK("send_done", 1'b0, send_request)
        rd(CQC_STAT_ADDR, r);
        `CHK("empty", 1'b1, r[CQC_EMPTY_IF_BIT])
    endtask

    // Abort by writing zero over a set request
    task automatic s_abort;
        wr(CQC_CTRL_ADDR, 32'h0000_0100);
        wr(CQC_CTRL_ADDR, 32'h0000_0200);
        abort_seen = 0;
        wr(CQC_CTRL_ADDR, CQC_ZERO_WORD);
        `CHK("abort_pulse", 1, abort_seen)
        `CHK("send_abt_wr", 1'b0, send_request)
        // Request again so the abort event has a set bit to refresh
        wr(CQC_CTRL_ADDR, 32'h0000_0200);
        `CHK("send_again", 1'b1, send_request)
        ev(5'b01000);
        `CHK("send_abt", 1'b0, send_request)
        rd(CQC_STAT_ADDR, r);
        `CHK("abt_flag", 1'b1, r[CQC_ABT_BIT])
        wr(CQC_CTRL_ADDR, 32'h0000_0200);
        rd(CQC_STAT_ADDR, r);
        `CHK("abt_on_send", 1'b0, r[CQC_ABT_BIT])
        ev(5'b10000);
        rd(CQC_STAT_ADDR, r);
        `CHK("abt_ok", 1'b0, r[CQC_ABT_BIT])
        `CHK("ci_field", 5'h01, r[CQC_CI_MSB:CQC_CI_LSB])
    endtask

    // Exhausted flag sticks; enables gate each source
    task automatic s_irq;
        ev(5'b00001);
        repeat (20) @(negedge mclk);
        rd(CQC_STAT_ADDR, r);
        `CHK("att_flag", 1'b1, r[CQC_ATT_IF_BIT])
        `CHK("irq_off", 3'b000, irq)
        wr(CQC_CTRL_ADDR, 32'h0000_0015);
        `CHK("irq_on", 3'b111, irq)
        wr(CQC_STAT_ADDR, CQC_ZERO_WORD);
        `CHK("att_clr", 1'b0, irq.att)
        wr(CQC_CTRL_ADDR, 32'h0000_0104);
        `CHK("irq_one", 3'b000, irq)
    endtask

    // Queue reset, host polls until the bit reads zero
    task automatic s_qreset;
        int n;
        // A raised outcome flag shows that the queue reset clears it
        ev(5'b00100);
        wr(CQC_CTRL_ADDR, 32'h0000_0400);
        n = 0;
        r = 32'h0000_0400;
        while (r[CQC_RST_REQ_BIT] !== 1'b0 && n < 8) begin
            rd(CQC_CTRL_ADDR, r);
            n++;
        end
        `CHK("rst_poll", 1'b0, r[CQC_RST_REQ_BIT])
        `CHK("q_cleared", 16'h0000, queue)
        rd(CQC_STAT_ADDR, r);
        `CHK("stat_qrst", 32'h0000_0005, r)
    endtask

    // Unused bit positions and an unmapped word
    task automatic s_unused;
        wr(CQC_CTRL_ADDR, 32'h0000_F86A);
        rd(CQC_CTRL_ADDR, r);
        `CHK("ctrl_unused", 16'h0080, r[15:0])
        wr(CQC_STAT_ADDR, 32'hFFFF_FFFF);
        rd(CQC_STAT_ADDR, r);
        `CHK("stat_unused", 16'h0005, r[15:0])
        wr(12'h058, 32'hFFFF_FFFF);
        rd(12'h058, r);
        `CHK("unmapped", CQC_ZERO_WORD, r)
    endtask

    initial begin
        s_reset();
        s_fill();
        s_send();
        s_abort();
        s_irq();
        s_qreset();
        s_unused();
        wrap_up();
    end
endmodule
`default_nettype wire
